// >>> hw/cdt_regs.sv
// Cable diagnostic configuration bank: APB slave, run control, peak slots, interrupt.
// Assumes an APB master on clock_in and a reflectometry engine on the same clock.
`timescale 1ns/1ps
module cdt_regs (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Length estimation engine.
    input wire logic len_done_in,
    input wire logic [7:0] length_est_result_in,
    output logic len_start_out,
    // Reflectometry engine.
    input wire logic tdr_done_in,
    input wire logic tdr_fail_in,
    input wire cdt_pkg::cdt_peak_type peak_in,
    output logic tdr_start_out,
    output cdt_pkg::cdt_cfg_type cfg_out,
    // Interrupt.
    output logic irq_out
);
    cdt_pkg::cdt_state_type s_r;
    cdt_pkg::cdt_state_type s_nxt;

    logic len_busy;
    logic len_done;
    logic len_finish;
    logic tdr_busy;
    logic tdr_done;
    logic tdr_fail;
    logic tdr_finish;
    logic [7:0] slot_q;
    logic [3:0] slot_wr_addr;
    logic [3:0] slot_rd_addr;
    logic [9:0] idx;
    logic setup;
    logic wr_take;
    logic [31:0] rd_word;
    logic rd_hit;

    // Averaging code to cycle count; the reserved code is held at the largest count.
    function automatic logic [6:0] avg_count(input logic [2:0] code);
        logic [6:0] n;
        n = (code == cdt_pkg::AVG_RESERVED) ? 7'h40 : 7'((8'h01 << code) & 8'h7F);
        return n;
    endfunction

    // Slot of a peak; transmit peaks move to receive slots under bypass.
    function automatic logic [3:0] slot_of(input logic rx, input logic [2:0] i,
                                           input logic byp);
        logic [3:0] base;
        base = (rx || byp) ? 4'(cdt_pkg::PEAKS_PER_PAIR) : 4'h0;
        return 4'(base + {1'b0, i});
    endfunction

    assign idx = paddr[11:2];
    assign setup = psel && !penable;
    assign wr_take = psel && penable && s_r.pready && pwrite;
    assign slot_wr_addr = slot_of(peak_in.rx_pair, peak_in.index, s_r.tx_byp); // [R6]
    assign slot_rd_addr = 4'(idx - cdt_pkg::IDX_SLOT_BASE);

    // Length estimation run.
    cdt_run_seq u_len_seq (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_req_in(s_r.len_req),
        .done_in(len_done_in),
        .fail_in(1'b0),
        .start_out(len_start_out),
        .busy_out(len_busy),
        .done_out(len_done),
        .fail_out(),
        .finish_out(len_finish)
    );

    // Reflectometry run.
    cdt_run_seq u_tdr_seq (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .start_req_in(s_r.tdr_req),
        .done_in(tdr_done_in),
        .fail_in(tdr_fail_in),
        .start_out(tdr_start_out),
        .busy_out(tdr_busy),
        .done_out(tdr_done),
        .fail_out(tdr_fail),
        .finish_out(tdr_finish)
    );

    // Peak slots.
    cdt_slot_mem #(
        .DEPTH(cdt_pkg::SLOT_COUNT),
        .WIDTH(8)
    ) u_slots (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .wr_en_in(peak_in.valid),
        .wr_addr_in(slot_wr_addr),
        .wr_data_in(peak_in.location),
        .rd_addr_in(slot_rd_addr),
        .rd_data_out(slot_q)
    );

    // Read mux; reserved read-only bits are tied to zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (idx)
            cdt_pkg::IDX_LEN_CTRL: begin
                rd_word[cdt_pkg::LEN_DONE_BIT] = len_done;
                rd_word[cdt_pkg::LEN_RES_LSB +: 8] = s_r.len_result;
                rd_word[2:0] = s_r.len_avg; // [R2] [R14]
            end
            cdt_pkg::IDX_DIAG_MAIN: begin
                rd_word[cdt_pkg::CROSS_DIS_BIT] = s_r.cross_dis;
                rd_word[cdt_pkg::TX_BYP_BIT] = s_r.tx_byp;
                rd_word[cdt_pkg::RX_BYP_BIT] = 1'b0; // [R7]
                rd_word[cdt_pkg::RSV_ONE_BIT] = s_r.rsv_one;
                rd_word[cdt_pkg::AVG_LSB +: 3] = s_r.avg_code; // [R9] [R14]
            end
            cdt_pkg::IDX_DIAG_PULSE: rd_word[15:0] = s_r.pulse;
            cdt_pkg::IDX_DIAG_LISTEN: rd_word[15:0] = s_r.listen;
            cdt_pkg::IDX_DIAG_THRESH: rd_word[15:0] = s_r.thresh;
            cdt_pkg::IDX_DIAG_STATUS: begin
                rd_word[cdt_pkg::TDR_DONE_BIT] = tdr_done; // [R16]
                rd_word[cdt_pkg::TDR_FAIL_BIT] = tdr_fail;
            end
            cdt_pkg::IDX_IRQ_STATUS: rd_word[2:0] = s_r.irq_st;
            cdt_pkg::IDX_IRQ_MASK: rd_word[2:0] = s_r.irq_mask;
            default: begin
                if (idx >= cdt_pkg::IDX_SLOT_BASE &&
                    idx < cdt_pkg::IDX_SLOT_BASE + 10'(cdt_pkg::SLOT_COUNT)) begin
                    rd_word[7:0] = slot_q;
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    // Next state: bus answer one wait state, writes at the completing edge.
    always_comb begin
        s_nxt = s_r;
        s_nxt.len_req = 1'b0;
        s_nxt.tdr_req = 1'b0;
        s_nxt.pready = psel && penable && !s_r.pready;
        s_nxt.pslverr = 1'b0;
        if (psel && penable && !s_r.pready) begin
            s_nxt.prdata = pwrite ? 32'h0000_0000 : rd_word;
            s_nxt.pslverr = !rd_hit || (paddr[1:0] != 2'h0);
        end
        if (wr_take && !s_r.pslverr) begin
            case (idx)
                cdt_pkg::IDX_LEN_CTRL: begin
                    s_nxt.len_req = pwdata[cdt_pkg::LEN_START_BIT] && !len_busy; // [R1] [R17]
                    s_nxt.len_avg = pwdata[2:0]; // [R2]
                end
                cdt_pkg::IDX_DIAG_MAIN: begin
                    s_nxt.cross_dis = pwdata[cdt_pkg::CROSS_DIS_BIT]; // [R3]
                    s_nxt.tx_byp = pwdata[cdt_pkg::TX_BYP_BIT]; // [R5]
                    s_nxt.rsv_one = pwdata[cdt_pkg::RSV_ONE_BIT];
                    s_nxt.avg_code = pwdata[cdt_pkg::AVG_LSB +: 3]; // [R9]
                end
                cdt_pkg::IDX_DIAG_PULSE: s_nxt.pulse = pwdata[15:0]; // [R10]
                cdt_pkg::IDX_DIAG_LISTEN: s_nxt.listen = pwdata[15:0]; // [R11]
                cdt_pkg::IDX_DIAG_THRESH: s_nxt.thresh = pwdata[15:0]; // [R12]
                cdt_pkg::IDX_DIAG_STATUS: begin
                    s_nxt.tdr_req = pwdata[cdt_pkg::TDR_START_BIT] && !tdr_busy; // [R17]
                end
                cdt_pkg::IDX_IRQ_STATUS: s_nxt.irq_st = s_r.irq_st & ~pwdata[2:0];
                cdt_pkg::IDX_IRQ_MASK: s_nxt.irq_mask = pwdata[2:0];
                default: s_nxt.pslverr = 1'b0;
            endcase
        end
        // The length result is caught on the engine's done pulse only.
        if (len_busy && len_done_in) begin
            s_nxt.len_result = length_est_result_in;
        end
        // Events are applied after the clear so that a set in the same cycle wins.
        s_nxt.irq_st[cdt_pkg::IRQ_LEN_DONE] = s_nxt.irq_st[cdt_pkg::IRQ_LEN_DONE] | len_finish;
        s_nxt.irq_st[cdt_pkg::IRQ_TDR_DONE] = s_nxt.irq_st[cdt_pkg::IRQ_TDR_DONE] | tdr_finish;
        s_nxt.irq_st[cdt_pkg::IRQ_TDR_FAIL] = s_nxt.irq_st[cdt_pkg::IRQ_TDR_FAIL] |
            (tdr_finish && tdr_fail);
        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);
    end

    // State register with documented reset values.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_r <= '0;
            s_r.len_avg <= cdt_pkg::LEN_AVG_RST;
            s_r.rsv_one <= 1'b1;
            s_r.avg_code <= cdt_pkg::AVG_CODE_RST;
            s_r.pulse <= cdt_pkg::PULSE_RST;
            s_r.listen <= cdt_pkg::LISTEN_RST;
            s_r.thresh <= cdt_pkg::THRESH_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs come straight from the state register.
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq_out = s_r.irq;
    // Cross mode sends the engine to listen on the other pair.
    assign cfg_out.cross_mode = !s_r.cross_dis; // [R3] [R4]
    assign cfg_out.tx_pair_en = !s_r.tx_byp; // [R5]
    assign cfg_out.rx_pair_en = 1'b1; // [R7]
    assign cfg_out.avg_cycles = avg_count(s_r.avg_code); // [R9]
    assign cfg_out.pulse_ref = s_r.pulse[3:0]; // [R10]
    assign cfg_out.listen_len = s_r.listen[15:8]; // [R11]
    assign cfg_out.short_thresh = s_r.thresh[cdt_pkg::THRESH_LSB +: 5]; // [R12]
    assign cfg_out.len_avg = s_r.len_avg; // [R2]

    // Checks.
    property p_len_start;
        @(posedge clock_in) disable iff (rst_in)
        wr_take && idx == cdt_pkg::IDX_LEN_CTRL && pwdata[15] && !len_busy && paddr[1:0] == 2'h0
        |=> ##1 len_start_out ##1 !len_start_out && len_busy;
    endproperty
    a_len_start: assert property (p_len_start) else $error("Length start lost."); // [R1]

    property p_start_reads_zero;
        @(posedge clock_in) disable iff (rst_in)
        pready && !pwrite && idx == cdt_pkg::IDX_LEN_CTRL |-> !prdata[15] && prdata[3] == 1'b0;
    endproperty
    a_start_reads_zero: assert property (p_start_reads_zero) else $error("Bad read."); // [R14]

    property p_rx_byp_zero;
        @(posedge clock_in) disable iff (rst_in)
        pready && !pwrite && idx == cdt_pkg::IDX_DIAG_MAIN |-> prdata[12] == 1'b0 &&
        prdata[7:0] == 8'h00 && prdata[15] == 1'b0;
    endproperty
    a_rx_byp_zero: assert property (p_rx_byp_zero) else $error("Reserved bit set."); // [R7]

    property p_cross;
        @(posedge clock_in) disable iff (rst_in)
        wr_take && idx == cdt_pkg::IDX_DIAG_MAIN && !pslverr
        |=> cfg_out.cross_mode == !$past(pwdata[14]) && cfg_out.tx_pair_en == !$past(pwdata[13]);
    endproperty
    a_cross: assert property (p_cross) else $error("Mode bits wrong."); // [R3]

    property p_avg;
        @(posedge clock_in) disable iff (rst_in)
        s_r.avg_code != 3'h7 |-> cfg_out.avg_cycles == (7'h40 >> (3'h6 - s_r.avg_code));
    endproperty
    a_avg: assert property (p_avg) else $error("Average count wrong."); // [R9]

    property p_bypass_slot;
        @(posedge clock_in) disable iff (rst_in)
        peak_in.valid && s_r.tx_byp |-> slot_wr_addr >= 4'h5;
    endproperty
    a_bypass_slot: assert property (p_bypass_slot) else $error("Peak in transmit slot."); // [R6]

    property p_fields_hold;
        @(posedge clock_in) disable iff (rst_in)
        !wr_take ##1 1'b1 |-> $stable(s_r.pulse) && $stable(s_r.listen) && $stable(s_r.thresh);
    endproperty
    a_fields_hold: assert property (p_fields_hold) else $error("Field moved."); // [R10]

    property p_fail_status;
        @(posedge clock_in) disable iff (rst_in)
        tdr_finish && tdr_fail |=> s_r.irq_st[2] && s_r.irq_st[1];
    endproperty
    a_fail_status: assert property (p_fail_status) else $error("Fail not flagged."); // [R16]

    property p_irq;
        @(posedge clock_in) disable iff (rst_in)
        irq_out == |(s_r.irq_st & s_r.irq_mask);
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt mismatch.");

    c_len_run: cover property (@(posedge clock_in) len_start_out ##[1:200] len_finish);
    c_tdr_fail: cover property (@(posedge clock_in) tdr_finish && tdr_fail);
    c_bypass_peak: cover property (@(posedge clock_in) peak_in.valid && s_r.tx_byp);
    c_irq: cover property (@(posedge clock_in) irq_out);
endmodule

// >>> hw/cdt_pkg.sv
// Package of the cable diagnostic configuration register bank.
// Assumes a 32-bit APB master; register indices are word numbers, byte address is four times.
// How it works
// R1: Writing start bit 15 launches length estimation.
// R2: Length averaging field bits 2:0, reset 001.
// R3: Cross-disable bit 14 forces regular mode only.
// R4: Cross mode listens on the other pair.
// R5: Bit 13 set skips the transmit pair.
// R6: Transmit bypass moves results into receive slots.
// R7: Receive bypass bit 12 reads zero, read-only.
// R8: Software writes one to reserved bit 11.
// R9: Field 10:8 picks 1 to 64 averaged cycles.
// R10: Pulse register bits 3:0, reset 0001.
// R11: Listen register bits 15:8, reset A0.
// R12: Threshold register bits 12:8, reset 0D.
// R13: Software ignores reserved read-write field values.
// R14: Read-only reserved bits ignore writes, read zero.
// R15: Software trusts peaks only after done reads one.
// R16: Fail and done status bits, read-only.
// R17: Start ignored while a run is busy.
package cdt_pkg;
    // Register indices.
    localparam logic [9:0] IDX_LEN_CTRL = 10'h155;
    localparam logic [9:0] IDX_DIAG_MAIN = 10'h170;
    localparam logic [9:0] IDX_DIAG_PULSE = 10'h171;
    localparam logic [9:0] IDX_DIAG_LISTEN = 10'h173;
    localparam logic [9:0] IDX_DIAG_THRESH = 10'h177;
    localparam logic [9:0] IDX_DIAG_STATUS = 10'h01E;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h190;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h191;
    localparam logic [9:0] IDX_SLOT_BASE = 10'h1A0;
    // Field positions.
    localparam int LEN_START_BIT = 15;
    localparam int LEN_DONE_BIT = 12;
    localparam int LEN_RES_LSB = 4;
    localparam int CROSS_DIS_BIT = 14;
    localparam int TX_BYP_BIT = 13;
    localparam int RX_BYP_BIT = 12;
    localparam int RSV_ONE_BIT = 11;
    localparam int AVG_LSB = 8;
    localparam int THRESH_LSB = 8;
    localparam int TDR_START_BIT = 15;
    localparam int TDR_DONE_BIT = 1;
    localparam int TDR_FAIL_BIT = 0;
    // Reset values, the threshold mask and the reserved averaging code.
    localparam logic [2:0] LEN_AVG_RST = 3'h1;
    localparam logic [2:0] AVG_CODE_RST = 3'h6;
    localparam logic [15:0] PULSE_RST = 16'hC851;
    localparam logic [15:0] LISTEN_RST = 16'hA01E;
    localparam logic [15:0] THRESH_RST = 16'h0D96;
    localparam logic [15:0] THRESH_MASK = 16'hFFFF;
    localparam logic [2:0] AVG_RESERVED = 3'h7;
    // Interrupt status bits.
    localparam int IRQ_LEN_DONE = 0;
    localparam int IRQ_TDR_DONE = 1;
    localparam int IRQ_TDR_FAIL = 2;
    // Peak slots: five per pair.
    localparam int PEAKS_PER_PAIR = 5;
    localparam int SLOT_COUNT = 10;

    // Settings handed to the reflectometry engine.
    typedef struct packed {
        logic cross_mode;
        logic tx_pair_en;
        logic rx_pair_en;
        logic [6:0] avg_cycles;
        logic [3:0] pulse_ref;
        logic [7:0] listen_len;
        logic [4:0] short_thresh;
        logic [2:0] len_avg;
    } cdt_cfg_type;

    // One peak location reported by the engine.
    typedef struct packed {
        logic valid;
        logic rx_pair;
        logic [2:0] index;
        logic [7:0] location;
    } cdt_peak_type;

    // Register state of the bank.
    typedef struct packed {
        logic [2:0] len_avg;
        logic cross_dis;
        logic tx_byp;
        logic rsv_one;
        logic [2:0] avg_code;
        logic [15:0] pulse;
        logic [15:0] listen;
        logic [15:0] thresh;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic [7:0] len_result;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic len_req;
        logic tdr_req;
    } cdt_state_type;

    // Run sequencer state.
    typedef enum logic [0:0] {
        RUN_IDLE = 1'b0,
        RUN_BUSY = 1'b1
    } cdt_run_state_type;
endpackage

// >>> hw/cdt_run_seq.sv
// Start and completion handshake for one measurement run.
// Assumes the engine on the same clock, answering with a one-cycle done pulse.
`timescale 1ns/1ps
module cdt_run_seq (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Request from the register bank.
    input wire logic start_req_in,
    // Answer from the engine.
    input wire logic done_in,
    input wire logic fail_in,
    // Run state.
    output logic start_out,
    output logic busy_out,
    output logic done_out,
    output logic fail_out,
    output logic finish_out
);
    typedef struct packed {
        cdt_pkg::cdt_run_state_type st;
        logic start;
        logic done;
        logic fail;
        logic finish;
    } cdt_seq_type;

    cdt_seq_type s_r;
    cdt_seq_type s_nxt;

    // A start during a run is dropped so that one launch gives one result.
    always_comb begin
        s_nxt = s_r;
        s_nxt.start = 1'b0;
        s_nxt.finish = 1'b0;
        case (s_r.st)
            cdt_pkg::RUN_IDLE: begin
                if (start_req_in) begin // [R1] [R17]
                    s_nxt.st = cdt_pkg::RUN_BUSY;
                    s_nxt.start = 1'b1;
                    s_nxt.done = 1'b0;
                    s_nxt.fail = 1'b0;
                end
            end
            cdt_pkg::RUN_BUSY: begin
                if (done_in) begin // [R16]
                    s_nxt.st = cdt_pkg::RUN_IDLE;
                    s_nxt.done = 1'b1;
                    s_nxt.fail = fail_in;
                    s_nxt.finish = 1'b1;
                end
            end
            default: s_nxt.st = cdt_pkg::RUN_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign start_out = s_r.start;
    assign busy_out = (s_r.st == cdt_pkg::RUN_BUSY);
    assign done_out = s_r.done;
    assign fail_out = s_r.fail;
    assign finish_out = s_r.finish;

    property p_no_restart;
        @(posedge clock_in) disable iff (rst_in)
        busy_out && !done_in |=> !start_out;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("Start while busy."); // [R17]

    property p_fail_on_done;
        @(posedge clock_in) disable iff (rst_in)
        busy_out && done_in |=> done_out && (fail_out == $past(fail_in)) && !busy_out;
    endproperty
    a_fail_on_done: assert property (p_fail_on_done) else $error("Bad end of run."); // [R16]
endmodule

// >>> hw/cdt_slot_mem.sv
// Peak location slots, one byte each, with a registered read port.
// Assumes one write and one read per cycle; read data follow one edge after the address.
`timescale 1ns/1ps
module cdt_slot_mem #(
    parameter int DEPTH = 10,
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_in,
    // Write port.
    input wire logic wr_en_in,
    input wire logic [3:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    // Read port.
    input wire logic [3:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] q_r;

    // Slots clear on reset only; a new run leaves peaks of an earlier run in slots that it does not write.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
            q_r <= '0;
        end else begin
            if (wr_en_in && int'(wr_addr_in) < DEPTH) begin
                mem_r[wr_addr_in] <= wr_data_in;
            end
            q_r <= (int'(rd_addr_in) < DEPTH) ? mem_r[rd_addr_in] : '0;
        end
    end

    assign rd_data_out = q_r;
endmodule

// >>> bench/tb.sv
// Self-checking bench for the cable diagnostic configuration bank.
// Assumes cdt_regs and cdt_pkg are compiled first; APB master and engines are driven here.
`timescale 1ns/1ps
module tb;
    // Clock, reset, bus and engine stimulus.
    logic clock_in;
    logic rst_in;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic len_done_in;
    logic [7:0] length_est_result_in;
    logic len_start_out;
    logic tdr_done_in;
    logic tdr_fail_in;
    logic tdr_start_out;
    logic irq_out;
    cdt_pkg::cdt_peak_type peak_in;
    cdt_pkg::cdt_cfg_type cfg_out;
    int errors;
    int compares;
    int len_pulses;
    int tdr_pulses;

    // Device under test.
    cdt_regs uut (
        .clock_in(clock_in), .rst_in(rst_in), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .len_done_in(len_done_in),
        .length_est_result_in(length_est_result_in), .len_start_out(len_start_out),
        .tdr_done_in(tdr_done_in), .tdr_fail_in(tdr_fail_in), .peak_in(peak_in),
        .tdr_start_out(tdr_start_out), .cfg_out(cfg_out), .irq_out(irq_out)
    );

    // Free-running 100 MHz clock.
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    // Start pulses are counted so a missing or doubled launch shows up.
    always @(posedge clock_in) begin
        if (len_start_out === 1'b1) len_pulses++;
        if (tdr_start_out === 1'b1) tdr_pulses++;
    end

    // Ends the run with the verdict.
    task automatic summarize();
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // One comparison; four-state equality so an unknown never matches.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= wd;
        @(posedge clock_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            summarize();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Register write and checked register read.
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
        @(posedge clock_in); // Registered outputs take the new value at the completing edge.
    endtask

    task automatic rdchk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 32'h0, r, e);
        chk(nm, exp, r);
        chk({nm, " slverr"}, 32'h0, {31'h0, e});
    endtask

    // Reset values of the length, main, pulse, listen and threshold registers and of five settings handed to the engine.
    task automatic t_reset();
        rdchk("len ctrl", cdt_pkg::IDX_LEN_CTRL, 32'h0000_0001);
        rdchk("diag main", cdt_pkg::IDX_DIAG_MAIN, 32'h0000_0E00);
        rdchk("pulse", cdt_pkg::IDX_DIAG_PULSE, 32'h0000_C851);
        rdchk("listen", cdt_pkg::IDX_DIAG_LISTEN, 32'h0000_A01E);
        rdchk("thresh", cdt_pkg::IDX_DIAG_THRESH, 32'h0000_0D96);
        chk("cfg cross", 32'h1, {31'h0, cfg_out.cross_mode});
        chk("cfg tx en", 32'h1, {31'h0, cfg_out.tx_pair_en});
        chk("cfg avg", 32'h40, {25'h0, cfg_out.avg_cycles});
        chk("cfg listen", 32'hA0, {24'h0, cfg_out.listen_len});
        chk("cfg thresh", 32'h0D, {27'h0, cfg_out.short_thresh});
    endtask

    // All ones into the main register: read-only bits stay zero, modes follow.
    task automatic t_main();
        wr(cdt_pkg::IDX_DIAG_MAIN, 32'hFFFF_FFFF);
        rdchk("main ones", cdt_pkg::IDX_DIAG_MAIN, 32'h0000_6F00);
        chk("cross off", 32'h0, {31'h0, cfg_out.cross_mode});
        chk("tx bypass", 32'h0, {31'h0, cfg_out.tx_pair_en});
        chk("rx kept", 32'h1, {31'h0, cfg_out.rx_pair_en});
        chk("avg reserved", 32'h40, {25'h0, cfg_out.avg_cycles});
        wr(cdt_pkg::IDX_DIAG_PULSE, 32'h0000_1234);
        rdchk("pulse rw", cdt_pkg::IDX_DIAG_PULSE, 32'h0000_1234);
        chk("cfg pulse", 32'h4, {28'h0, cfg_out.pulse_ref});
    endtask

    // Averaging codes 0 to 6 map to their powers of two.
    task automatic t_avg();
        for (int c = 0; c < 7; c++) begin
            wr(cdt_pkg::IDX_DIAG_MAIN, 32'h0000_0800 | (c << 8));
            chk("avg cycles", 32'h1 << c, {25'h0, cfg_out.avg_cycles});
        end
    endtask

    // Length run: one launch, repeat start ignored, result and event reported.
    task automatic t_len();
        wr(cdt_pkg::IDX_LEN_CTRL, 32'h0000_8003);
        repeat (3) @(posedge clock_in);
        chk("len launch", 32'h1, len_pulses);
        chk("cfg len avg", 32'h3, {29'h0, cfg_out.len_avg});
        rdchk("len busy", cdt_pkg::IDX_LEN_CTRL, 32'h0000_0003);
        wr(cdt_pkg::IDX_LEN_CTRL, 32'h0000_8003);
        repeat (3) @(posedge clock_in);
        chk("len no relaunch", 32'h1, len_pulses);
        @(posedge clock_in);
        len_done_in <= 1'b1;
        length_est_result_in <= 8'hA5;
        @(posedge clock_in);
        len_done_in <= 1'b0;
        rdchk("len result", cdt_pkg::IDX_LEN_CTRL, 32'h0000_1A53);
        rdchk("irq status", cdt_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
        chk("irq masked", 32'h0, {31'h0, irq_out});
        wr(cdt_pkg::IDX_IRQ_MASK, 32'h0000_0001);
        chk("irq raised", 32'h1, {31'h0, irq_out});
        wr(cdt_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
        chk("irq cleared", 32'h0, {31'h0, irq_out});
    endtask

    // Reflectometry with transmit bypass: peak lands in a receive slot, fail is reported.
    task automatic t_tdr();
        wr(cdt_pkg::IDX_DIAG_MAIN, 32'h0000_2800);
        wr(cdt_pkg::IDX_DIAG_STATUS, 32'h0000_8000);
        repeat (3) @(posedge clock_in);
        chk("tdr launch", 32'h1, tdr_pulses);
        @(posedge clock_in);
        peak_in <= '{valid: 1'b1, rx_pair: 1'b0, index: 3'h0, location: 8'h3C};
        @(posedge clock_in);
        peak_in <= '0;
        tdr_done_in <= 1'b1;
        tdr_fail_in <= 1'b1;
        @(posedge clock_in);
        tdr_done_in <= 1'b0;
        tdr_fail_in <= 1'b0;
        rdchk("diag status", cdt_pkg::IDX_DIAG_STATUS, 32'h0000_0003);
        rdchk("irq tdr", cdt_pkg::IDX_IRQ_STATUS, 32'h0000_0006);
        rdchk("rx slot", cdt_pkg::IDX_SLOT_BASE + 10'h005, 32'h0000_003C);
        rdchk("tx slot", cdt_pkg::IDX_SLOT_BASE, 32'h0000_0000);
    endtask

    // An unmapped index is refused with zero data.
    task automatic t_unmapped();
        logic [31:0] r;
        logic e;
        apb(1'b0, 10'h172, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask

    // Main sequence: reset for 20 cycles, then each scenario in turn.
    initial begin
        rst_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        len_done_in = 1'b0;
        length_est_result_in = 8'h00;
        tdr_done_in = 1'b0;
        tdr_fail_in = 1'b0;
        peak_in = '0;
        errors = 0;
        compares = 0;
        len_pulses = 0;
        tdr_pulses = 0;
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        t_reset();
        t_main();
        t_avg();
        t_len();
        t_tdr();
        t_unmapped();
        summarize();
    end
endmodule
